//--- mtg_pkg.sv
// mtg_pkg: register offsets, field positions, reset values and timing
// constants for the multimedia timer and gpio direction block.
// assumes: shared by every design file of the block; no logic here.
package mtg_pkg;

  // ==========================================================
  // widths
  // ==========================================================
  localparam int COUNT_W   = 20;   // timer counter width
  localparam int BYTE_W    = 8;    // every register is one byte
  localparam int IO_ADDR_W = 3;    // i/o window offset width
  localparam int CFG_ADDR_W = 8;   // config space offset width
  localparam int GPIO_N    = 8;    // general purpose pins

  // ==========================================================
  // register offsets
  // ==========================================================
  localparam logic [CFG_ADDR_W-1:0] CFG_TIMER_OFS = 8'h64; // config byte
  localparam logic [IO_ADDR_W-1:0]  IO_STATUS_OFS = 3'h0;  // status byte
  localparam logic [IO_ADDR_W-1:0]  IO_CNT_LO_OFS = 3'h1;  // count low
  localparam logic [IO_ADDR_W-1:0]  IO_CNT_MI_OFS = 3'h2;  // count mid
  localparam logic [IO_ADDR_W-1:0]  IO_CNT_HI_OFS = 3'h3;  // count high
  localparam logic [IO_ADDR_W-1:0]  IO_DIR_OFS    = 3'h4;  // pin direction

  // ==========================================================
  // field positions and masks
  // ==========================================================
  localparam int CFG_FAST_BIT    = 2;  // fast_clock_select
  localparam int CFG_HOLD_BIT    = 1;  // timer_hold_reset
  localparam int ST_PRELOAD_BIT  = 3;  // preload_indicator
  localparam int ST_RUN_BIT      = 2;  // run_control
  localparam int ST_FLAG_BIT     = 1;  // zero_count_flag
  localparam int ST_IEN_BIT      = 0;  // irq_enable
  localparam logic [BYTE_W-1:0] CFG_RW_MASK = 8'h06; // writable cfg bits
  localparam logic [BYTE_W-1:0] ST_CTL_MASK = 8'h0D; // plain rw status
  localparam logic [BYTE_W-1:0] HI_RW_MASK  = 8'h0F; // high count nibble

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00; // all registers

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10;   // core_clk at 100 MHz
  localparam int TIME_BASE_NS  = 570;  // slow timer base period
  localparam int TICK_CYCLES   = (TIME_BASE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

endpackage

//--- mtg_count_if.sv
// mtg_count_if: bundle between the register front end and the counter
// assumes: one clock domain, driven by mtg_timer and mtg_counter.
`timescale 1ns/10ps
interface mtg_count_if
  import mtg_pkg::*;
();
  logic               clear;      // timer held in reset
  logic               tick;       // one-cycle count enable
  logic               run;        // counting allowed
  logic               load;       // load preload value now
  logic [COUNT_W-1:0] load_value; // preload value
  logic [COUNT_W-1:0] count;      // live counter value
  logic               wrap;       // pulse: counter rolled to zero

  modport ctrl (output clear, tick, run, load, load_value,
                input  count, wrap);
  modport core (input  clear, tick, run, load, load_value,
                output count, wrap);
endinterface

//--- mtg_time_base.sv
// mtg_time_base: divides core_clk down to the slow timer base pulse
// assumes: clear is the timer reset; fast bypasses the divider.
`timescale 1ns/10ps
module mtg_time_base
  import mtg_pkg::*;
#(
  parameter int DIV = TICK_CYCLES   // core cycles per base period
) (
  input  wire logic core_clk,
  input  wire logic clear,          // timer reset, synchronous
  input  wire logic fast,           // use core clock directly
  output      logic tick            // one-cycle base pulse
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_reg;            // cycle counter
  logic [W-1:0] div_next;
  wire          at_last = (div_reg == LAST);

  assign div_next = (clear || at_last) ? '0 : div_reg + W'(1);
  // fast mode ticks every core cycle, else once per base period
  assign tick     = !clear && (fast || at_last);

  // ==========================================================
  // divider counter
  // ==========================================================
  always_ff @(posedge core_clk) begin
    div_reg <= div_next;
  end
endmodule

//--- mtg_counter.sv
// mtg_counter: 20-bit up counter with load, stop and wrap detection
// assumes: all controls come through mtg_count_if from mtg_timer.
`timescale 1ns/10ps
module mtg_counter
  import mtg_pkg::*;
(
  input  wire logic  core_clk,
  mtg_count_if.core  cif
);
  logic [COUNT_W-1:0] count_reg;   // live count
  logic [COUNT_W-1:0] count_next;
  wire                step = cif.tick && cif.run && !cif.load;
  wire                at_max = (count_reg == {COUNT_W{1'b1}});

  // hold in reset first, then load, then step on base ticks
  assign count_next = cif.clear ? '0 :
                      cif.load  ? cif.load_value :
                      step      ? count_reg + COUNT_W'(1) :
                      count_reg;
  assign cif.count  = count_reg;
  // roll to zero is the zero-count event; counting carries on
  assign cif.wrap   = !cif.clear && step && at_max;

  // ==========================================================
  // counter register
  // ==========================================================
  always_ff @(posedge core_clk) begin
    count_reg <= count_next;
  end
endmodule

//--- mtg_timer.sv
// mtg_timer: multimedia timer with gpio direction register.
// holds the config byte (config space) and the i/o window bytes.
// assumes: the pci target decodes the two spaces and hands over single
// byte accesses as one-cycle read or write strobes on core_clk.
`timescale 1ns/10ps

// Functional notes
// - fast select counts on core clock
// - hold-reset bit keeps timer in reset
// - system reset also resets the timer
// - reserved bits always read zero
// - preload set: start from count registers
// - preload clear: start from zero/held value
// - run set: count from next base edge
// - run clear: counter stops, holds value
// - counter reaching zero sets interrupt flag
// - counter keeps running after the flag
// - writing one clears flag, zero ignored
// - interrupt request only while enabled
// - top four count bits at 03h
// - middle count byte at 02h
// - low count byte at 01h
// - direction bit zero output, one input
// - each pin controlled independently
// - counter is twenty bits wide
// - all registers accessed one byte each
// - config byte in config, rest in i/o
module mtg_timer
  import mtg_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES      // base period in cycles
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // config space byte access
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_rd,
  input  wire logic [CFG_ADDR_W-1:0] cfg_addr,
  input  wire logic [BYTE_W-1:0]     cfg_wdata,
  output      logic [BYTE_W-1:0]     cfg_rdata,
  // i/o window byte access
  input  wire logic                  io_wr,
  input  wire logic                  io_rd,
  input  wire logic [IO_ADDR_W-1:0]  io_addr,
  input  wire logic [BYTE_W-1:0]     io_wdata,
  output      logic [BYTE_W-1:0]     io_rdata,
  // timer interrupt and gpio direction
  output      logic                  timer_irq,
  output      logic [GPIO_N-1:0]     pin_direction_bits,
  output      logic [GPIO_N-1:0]     gpio_out_en
);

  // ==========================================================
  // registers
  // ==========================================================
  logic [BYTE_W-1:0] cfg_reg;        // timer_config_byte
  logic [BYTE_W-1:0] cfg_next;
  logic [BYTE_W-1:0] ctl_reg;        // status control bits
  logic [BYTE_W-1:0] ctl_next;
  logic              flag_reg;       // zero_count_flag
  logic              flag_next;
  logic [BYTE_W-1:0] pre_lo_reg;     // preload low byte
  logic [BYTE_W-1:0] pre_lo_next;
  logic [BYTE_W-1:0] pre_mi_reg;     // preload mid byte
  logic [BYTE_W-1:0] pre_mi_next;
  logic [BYTE_W-1:0] pre_hi_reg;     // preload high nibble
  logic [BYTE_W-1:0] pre_hi_next;
  logic [BYTE_W-1:0] dir_reg;        // pin_direction_byte
  logic [BYTE_W-1:0] dir_next;
  logic [BYTE_W-1:0] cfg_rdata_reg;  // config read data
  logic [BYTE_W-1:0] cfg_rdata_next;
  logic [BYTE_W-1:0] io_rdata_reg;   // i/o read data
  logic [BYTE_W-1:0] io_rdata_next;

  mtg_count_if cif ();               // counter bundle

  // ==========================================================
  // address decode
  // ==========================================================
  wire cfg_hit    = (cfg_addr == CFG_TIMER_OFS);
  wire cfg_wr_hit = cfg_wr && cfg_hit;
  wire io_st_hit  = (io_addr == IO_STATUS_OFS);
  wire io_lo_hit  = (io_addr == IO_CNT_LO_OFS);
  wire io_mi_hit  = (io_addr == IO_CNT_MI_OFS);
  wire io_hi_hit  = (io_addr == IO_CNT_HI_OFS);
  wire io_dir_hit = (io_addr == IO_DIR_OFS);
  wire st_wr      = io_wr && io_st_hit;
  wire lo_wr      = io_wr && io_lo_hit;
  wire mi_wr      = io_wr && io_mi_hit;
  wire hi_wr      = io_wr && io_hi_hit;
  wire dir_wr     = io_wr && io_dir_hit;

  // ==========================================================
  // control decode
  // ==========================================================
  wire fast_sel   = cfg_reg[CFG_FAST_BIT];
  // system reset or the hold bit both keep the timer in reset
  wire timer_rst  = !reset_n || cfg_reg[CFG_HOLD_BIT];
  wire run_now    = ctl_reg[ST_RUN_BIT];
  wire run_wr_val = io_wdata[ST_RUN_BIT];
  wire pre_wr_val = io_wdata[ST_PRELOAD_BIT];
  // a start is a status write that turns run on from off
  wire start      = st_wr && run_wr_val && !run_now;
  // preload only on a start with the indicator set; otherwise the
  // counter keeps what it held (zero after a timer reset)
  wire do_load    = start && pre_wr_val;
  wire flag_clr   = st_wr && io_wdata[ST_FLAG_BIT];

  // ==========================================================
  // next-state values
  // ==========================================================
  // reserved config bits are never stored, so they read zero
  assign cfg_next    = !reset_n ? RST_BYTE :
                       cfg_wr_hit ? (cfg_wdata & CFG_RW_MASK) :
                       cfg_reg;
  assign ctl_next    = !reset_n ? RST_BYTE :
                       st_wr ? (io_wdata & ST_CTL_MASK) :
                       ctl_reg;
  // set wins over a clear landing in the same cycle
  assign flag_next   = timer_rst ? 1'b0 :
                       cif.wrap  ? 1'b1 :
                       flag_clr  ? 1'b0 :
                       flag_reg;
  // count writes only touch the preload bytes, never status
  assign pre_lo_next = !reset_n ? RST_BYTE :
                       lo_wr ? io_wdata : pre_lo_reg;
  assign pre_mi_next = !reset_n ? RST_BYTE :
                       mi_wr ? io_wdata : pre_mi_reg;
  assign pre_hi_next = !reset_n ? RST_BYTE :
                       hi_wr ? (io_wdata & HI_RW_MASK) :
                       pre_hi_reg;
  assign dir_next    = !reset_n ? RST_BYTE :
                       dir_wr ? io_wdata : dir_reg;

  // ==========================================================
  // read data mux; live count is split across three bytes
  // ==========================================================
  wire [BYTE_W-1:0] st_view  = ctl_reg |
                               (BYTE_W'(flag_reg) << ST_FLAG_BIT);
  wire [BYTE_W-1:0] cnt_lo_v = cif.count[7:0];
  wire [BYTE_W-1:0] cnt_mi_v = cif.count[15:8];
  wire [BYTE_W-1:0] cnt_hi_v = {4'h0, cif.count[19:16]};
  // unmapped window offsets read as zero
  wire [BYTE_W-1:0] io_view  = io_st_hit  ? st_view  :
                               io_lo_hit  ? cnt_lo_v :
                               io_mi_hit  ? cnt_mi_v :
                               io_hi_hit  ? cnt_hi_v :
                               io_dir_hit ? dir_reg  : RST_BYTE;
  // the three count bytes are sampled on separate accesses, so a
  // carry may land between them; reading low first limits the skew
  assign io_rdata_next  = !reset_n ? RST_BYTE :
                          io_rd ? io_view : io_rdata_reg;
  assign cfg_rdata_next = !reset_n ? RST_BYTE :
                          cfg_rd ? (cfg_hit ? cfg_reg : RST_BYTE) :
                          cfg_rdata_reg;

  // ==========================================================
  // counter hookup
  // ==========================================================
  assign cif.clear      = timer_rst;
  assign cif.run        = run_now;
  assign cif.load       = do_load;
  assign cif.load_value = {pre_hi_reg[3:0], pre_mi_reg, pre_lo_reg};

  mtg_time_base #(
    .DIV      (TICK_DIV)
  ) u_base (
    .core_clk (core_clk),
    .clear    (timer_rst),
    .fast     (fast_sel),
    .tick     (cif.tick)
  );

  mtg_counter u_counter (
    .core_clk (core_clk),
    .cif      (cif.core)
  );

  // ==========================================================
  // register update; reset handled in the next-value terms
  // ==========================================================
  always_ff @(posedge core_clk) begin
    cfg_reg       <= cfg_next;
    ctl_reg       <= ctl_next;
    flag_reg      <= flag_next;
    pre_lo_reg    <= pre_lo_next;
    pre_mi_reg    <= pre_mi_next;
    pre_hi_reg    <= pre_hi_next;
    dir_reg       <= dir_next;
    io_rdata_reg  <= io_rdata_next;
    cfg_rdata_reg <= cfg_rdata_next;
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign cfg_rdata          = cfg_rdata_reg;
  assign io_rdata           = io_rdata_reg;
  // request only while the enable bit is set
  assign timer_irq          = flag_reg && ctl_reg[ST_IEN_BIT];
  assign pin_direction_bits = dir_reg;

  // one enable per pin; a zero direction bit drives the pin
  genvar gi;
  generate
    for (gi = 0; gi < GPIO_N; gi++) begin : g_pin
      assign gpio_out_en[gi] = !dir_reg[gi];
    end
  endgenerate

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // slow base tracker, read only by the checks below
  // ==========================================================
  localparam int GAP_W = $clog2(TICK_DIV + 1);
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(TICK_DIV - 1);

  logic [GAP_W-1:0] gap_reg;         // cycles since last tick
  logic [GAP_W-1:0] gap_next;
  logic             slow_seq_reg;    // last tick was a slow one
  logic             slow_seq_next;

  // a tick or a timer reset restarts the gap count
  assign gap_next      = (timer_rst || cif.tick) ? '0 :
                         gap_reg + GAP_W'(1);
  // fast mode or a timer reset breaks the slow tick chain, so the
  // first slow tick after either is not measured
  assign slow_seq_next = !timer_rst && !fast_sel &&
                         (slow_seq_reg || cif.tick);

  // helper registers, no effect on the timer itself
  always_ff @(posedge core_clk) begin
    gap_reg      <= gap_next;
    slow_seq_reg <= slow_seq_next;
  end

  // counting and the time base
  a_fast_step: assert property (
    fast_sel && run_now && !timer_rst && !do_load && !cif.wrap
    |=> cif.count == $past(cif.count) + COUNT_W'(1))
    else $error("fast mode did not step every cycle");

  // slow ticks sit exactly one base period apart
  a_slow_gap: assert property (
    cif.tick && !fast_sel && slow_seq_reg |-> gap_reg == GAP_LAST)
    else $error("slow base period wrong");

  // a stalled divider would leave the gap count climbing
  a_slow_due: assert property (
    !fast_sel && !timer_rst |-> gap_reg <= GAP_LAST)
    else $error("slow base tick overdue");

  // a running counter moves only on a base tick
  a_tick_only: assert property (
    run_now && !cif.tick && !timer_rst
    |=> cif.count == $past(cif.count))
    else $error("counter moved between ticks");

  // the clear lands one edge after the hold bit is seen
  a_hold_clear: assert property (
    cfg_reg[CFG_HOLD_BIT] |=> cif.count == '0 && !flag_reg)
    else $error("timer not held in reset");

  // reserved bits never show, whatever was written
  a_cfg_rsvd: assert property (
    (cfg_rdata & ~CFG_RW_MASK) == RST_BYTE &&
    (ctl_reg & ~ST_CTL_MASK) == RST_BYTE)
    else $error("reserved bits not zero");

  // a preload start takes all three preload bytes
  a_preload_go: assert property (
    do_load && !timer_rst |=> cif.count == $past(cif.load_value))
    else $error("preload value not loaded");

  // cleared run freezes the count
  a_stop_hold: assert property (
    !run_now && !timer_rst && !do_load
    |=> cif.count == $past(cif.count))
    else $error("stopped counter moved");

  // zero-count event, flag and request
  a_wrap_flag: assert property (
    cif.wrap && !cfg_wr |=> flag_reg && cif.count == '0)
    else $error("wrap did not set flag");

  // the wrap never drops run on its own
  a_keep_run: assert property (
    cif.wrap && !st_wr && !cfg_wr |=> run_now)
    else $error("counter paused after wrap");

  // write one clears unless a wrap lands at once
  a_flag_clear: assert property (
    flag_clr && !cif.wrap && !timer_rst |=> !flag_reg)
    else $error("write one did not clear flag");

  // a zero in the flag position is no clear
  a_flag_keep: assert property (
    flag_reg && st_wr && !io_wdata[ST_FLAG_BIT] && !timer_rst
    |=> flag_reg)
    else $error("write zero cleared flag");

  // request masked whenever the enable is off
  a_irq_gate: assert property (
    !ctl_reg[ST_IEN_BIT] |-> !timer_irq)
    else $error("irq raised while disabled");

  // count bytes sample the live counter at the read edge
  a_count_low: assert property (
    io_rd && io_lo_hit |=> io_rdata == $past(cif.count[7:0]))
    else $error("low count byte wrong");

  a_count_high: assert property (
    io_rd && io_hi_hit
    |=> io_rdata == {4'h0, $past(cif.count[19:16])})
    else $error("high count nibble wrong");

  a_count_mid: assert property (
    io_rd && io_mi_hit |=> io_rdata == $past(cif.count[15:8]))
    else $error("mid count byte wrong");

  // direction byte reads back as written, all eight bits
  a_dir_read: assert property (
    io_rd && io_dir_hit |=> io_rdata == $past(dir_reg))
    else $error("direction byte read wrong");

  // each pin enable is the inverse of its direction bit
  a_dir_write: assert property (
    dir_wr |=> gpio_out_en == ~$past(io_wdata))
    else $error("pin enables do not follow direction");

  c_wrap:       cover property (cif.wrap);
  c_flag_clear: cover property (flag_reg && flag_clr);
  c_preload:    cover property (do_load ##1 run_now [*3]);
  c_fast_run:   cover property (fast_sel && run_now && cif.tick);
  c_slow_tick:  cover property (cif.tick && !fast_sel && slow_seq_reg);

endmodule

//--- test_multimedia_timer_gpio_dir.sv
// test_multimedia_timer_gpio_dir: self-checking bench for mtg_timer.
// assumes: mtg_pkg compiled first; one byte access per strobe pulse.
`timescale 1ns/10ps
module test_multimedia_timer_gpio_dir;
  import mtg_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  // ==========================================================
  localparam int DIV = 4;                     // shortened base period
  logic                  core_clk  = 1'b0;    // 100 MHz core clock
  logic                  reset_n   = 1'b0;    // held low at start
  logic                  cfg_wr    = 1'b0;    // config write strobe
  logic                  cfg_rd    = 1'b0;    // config read strobe
  logic [CFG_ADDR_W-1:0] cfg_addr  = 8'h00;   // config offset
  logic [BYTE_W-1:0]     cfg_wdata = 8'h00;   // config write data
  logic [BYTE_W-1:0]     cfg_rdata;           // config read data
  logic                  io_wr     = 1'b0;    // i/o write strobe
  logic                  io_rd     = 1'b0;    // i/o read strobe
  logic [IO_ADDR_W-1:0]  io_addr   = 3'h0;    // i/o offset
  logic [BYTE_W-1:0]     io_wdata  = 8'h00;   // i/o write data
  logic [BYTE_W-1:0]     io_rdata;            // i/o read data
  logic                  timer_irq;           // interrupt level
  logic [GPIO_N-1:0]     pin_direction_bits;  // 1 = input
  logic [GPIO_N-1:0]     gpio_out_en;         // 1 = driving
  int                    n_fail    = 0;       // mismatches seen
  int                    n_tests   = 0;       // comparisons made

  always #5 core_clk = ~core_clk;

  mtg_timer #(.TICK_DIV(DIV)) mtg_timer_inst (
    .core_clk(core_clk), .reset_n(reset_n), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .timer_irq(timer_irq), .pin_direction_bits(pin_direction_bits),
    .gpio_out_en(gpio_out_en));

  // ==========================================================
  // shared tasks
  // ==========================================================
  // one compare; x or z in seen matches only the same x or z in exp
  task automatic check(input string what, input logic [19:0] seen,
                       input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobes rise at one falling edge, drop at the next
  task automatic iow(input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask

  // read data is registered, so settled at the following fall
  task automatic iord(input logic [2:0] a, output logic [7:0] d);
    @(negedge core_clk);
    io_rd = 1'b1;
    io_addr = a;
    @(negedge core_clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask

  task automatic cfgw(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask

  task automatic cfgr(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge core_clk);
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask

  // low byte first; only stable while the counter is stopped
  task automatic rdcnt(output logic [19:0] v);
    logic [7:0] l, m, h;
    iord(IO_CNT_LO_OFS, l);
    iord(IO_CNT_MI_OFS, m);
    iord(IO_CNT_HI_OFS, h);
    check("count high reserved", {16'h0, h[7:4]}, 20'h0);
    v = {h[3:0], m, l};
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  // reset values, unmapped reads, reserved bits
  task automatic t_reset_reserved();
    logic [7:0] d;
    for (int a = 0; a < 6; a++) begin
      iord(a[2:0], d);
      check("io reset value", {12'h0, d}, 20'h0);
    end
    cfgr(CFG_TIMER_OFS, d);
    check("cfg reset value", {12'h0, d}, 20'h0);
    check("out_en reset", {12'h0, gpio_out_en}, 20'hFF);
    cfgw(CFG_TIMER_OFS, 8'hFF);
    cfgr(CFG_TIMER_OFS, d);
    check("cfg reserved", {12'h0, d}, 20'h6);
    cfgw(CFG_TIMER_OFS, 8'h00);
    cfgr(8'h60, d);
    check("cfg other offset", {12'h0, d}, 20'h0);
    iow(IO_STATUS_OFS, 8'hF0);
    iord(IO_STATUS_OFS, d);
    check("status reserved", {12'h0, d}, 20'h0);
    iow(3'h5, 8'hFF);
    iord(3'h5, d);
    check("unmapped io", {12'h0, d}, 20'h0);
    $display("test reset_reserved done");
  endtask

  // preload start, stop/hold, resume, fast versus slow base
  task automatic t_count();
    logic [19:0] v0, v1;
    cfgw(CFG_TIMER_OFS, 8'h04);
    iow(IO_CNT_LO_OFS, 8'h34);
    iow(IO_CNT_MI_OFS, 8'h12);
    iow(IO_CNT_HI_OFS, 8'hFA);
    iow(IO_STATUS_OFS, 8'h0C);
    iow(IO_STATUS_OFS, 8'h08);
    rdcnt(v0);
    check("preload start",
          {19'h0, v0 >= 20'hA1234 && v0 <= 20'hA1238},
          20'h1);
    repeat (20) @(negedge core_clk);
    rdcnt(v1);
    check("held when stopped", v1, v0);
    // changed preload exposes a wrong reload on plain resume
    iow(IO_CNT_LO_OFS, 8'h00);
    iow(IO_STATUS_OFS, 8'h04);
    repeat (20) @(negedge core_clk);
    iow(IO_STATUS_OFS, 8'h00);
    rdcnt(v1);
    check("fast resume",
          {19'h0, v1 - v0 >= 18 && v1 - v0 <= 26}, 20'h1);
    cfgw(CFG_TIMER_OFS, 8'h00);
    v0 = v1;
    iow(IO_STATUS_OFS, 8'h04);
    repeat (20) @(negedge core_clk);
    iow(IO_STATUS_OFS, 8'h00);
    rdcnt(v1);
    check("slow resume",
          {19'h0, v1 - v0 >= 3 && v1 - v0 <= 8}, 20'h1);
    $display("test count done");
  endtask

  // wrap to zero, flag, enable, write-one clear
  task automatic t_wrap();
    logic [7:0]  d;
    logic [19:0] v;
    cfgw(CFG_TIMER_OFS, 8'h04);
    iow(IO_CNT_LO_OFS, 8'hF0);
    iow(IO_CNT_MI_OFS, 8'hFF);
    iow(IO_CNT_HI_OFS, 8'h0F);
    iow(IO_STATUS_OFS, 8'h0C);
    repeat (20) @(negedge core_clk);
    iord(IO_STATUS_OFS, d);
    check("flag on wrap", {12'h0, d}, 20'h0E);
    check("irq masked", {19'h0, timer_irq}, 20'h0);
    iow(IO_STATUS_OFS, 8'h0D);
    iord(IO_STATUS_OFS, d);
    check("write zero keeps flag", {12'h0, d}, 20'h0F);
    check("irq enabled", {19'h0, timer_irq}, 20'h1);
    iow(IO_CNT_MI_OFS, 8'h55);
    iord(IO_STATUS_OFS, d);
    check("count write", {12'h0, d}, 20'h0F);
    iow(IO_STATUS_OFS, 8'h0F);
    iord(IO_STATUS_OFS, d);
    check("write one clears", {12'h0, d}, 20'h0D);
    check("irq cleared", {19'h0, timer_irq}, 20'h0);
    iow(IO_STATUS_OFS, 8'h09);
    rdcnt(v);
    check("runs after wrap", {19'h0, v > 0 && v < 20'h100}, 20'h1);
    $display("test wrap done");
  endtask

  // hold-in-reset bit clears counter, keeps status controls
  task automatic t_hold();
    logic [7:0]  d;
    logic [19:0] v;
    cfgw(CFG_TIMER_OFS, 8'h06);
    rdcnt(v);
    check("hold clears count", v, 20'h0);
    cfgr(CFG_TIMER_OFS, d);
    check("hold readback", {12'h0, d}, 20'h06);
    iord(IO_STATUS_OFS, d);
    check("status kept", {12'h0, d}, 20'h09);
    cfgw(CFG_TIMER_OFS, 8'h04);
    $display("test hold done");
  endtask

  // each direction bit alone steers its own pin
  task automatic t_gpio();
    logic [7:0] d, p;
    for (int i = 0; i < 8; i++) begin
      p = 8'h01 << i;
      iow(IO_DIR_OFS, p);
      iord(IO_DIR_OFS, d);
      check("dir readback", {12'h0, d}, {12'h0, p});
      check("dir pins", {12'h0, pin_direction_bits}, {12'h0, p});
      check("out enables", {12'h0, gpio_out_en}, {12'h0, ~p});
    end
    $display("test gpio done");
  endtask

  // system reset in mid-run returns every register to zero
  task automatic t_sysreset();
    logic [7:0]  d;
    logic [19:0] v;
    iow(IO_STATUS_OFS, 8'h05);
    repeat (10) @(negedge core_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    rdcnt(v);
    check("count after reset", v, 20'h0);
    iord(IO_STATUS_OFS, d);
    check("status after reset", {12'h0, d}, 20'h0);
    cfgr(CFG_TIMER_OFS, d);
    check("cfg after reset", {12'h0, d}, 20'h0);
    check("dir after reset", {12'h0, pin_direction_bits}, 20'h0);
    $display("test sysreset done");
  endtask

  // ==========================================================
  // verdict, watchdog and main sequence
  // ==========================================================
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole run is well under 2000 cycles; allow ten times that
  initial begin
    #200000;
    n_fail++;
    results();
  end

  initial begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    t_reset_reserved();
    t_count();
    t_wrap();
    t_hold();
    t_gpio();
    t_sysreset();
    results();
  end
endmodule
